// [logic/fp_execute.v]
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "fp_execute_consts.vh"
module fp_execute #(
    parameter [7:0] float_divide_op        = 8'he0, // Arbitrary code
    parameter [7:0] widening_multiply_op   = 8'he1, // Arbitrary code
    parameter [7:0] float_equal_op         = 8'he2, // Arbitrary code
    parameter [7:0] float_gt_op            = 8'he3, // Arbitrary code
    parameter [7:0] multiply_accumulate_op = 8'he4, // Arbitrary code
    parameter [7:0] multiply_sum_op        = 8'he5, // Arbitrary code
    parameter [7:0] float_subtract_op      = 8'he6  // Arbitrary code
) (
    input  wire        clk_i,                     // Core clock
    input  wire        rst_i,                     // Async reset
    input  wire [11:0] addr_i,                    // Register address
    input  wire [31:0] wdata_i,                   // Write data
    input  wire        wr_i,                      // Write strobe
    input  wire        rd_i,                      // Read strobe
    output reg  [31:0] rdata_o,                   // Read data
    output reg         irq_o,                     // Interrupt level
    input  wire        issue_i,                   // Instruction issue
    input  wire [7:0]  opcode_i,                  // Opcode
    input  wire [7:0]  destination_field_i,       // Destination reg
    input  wire [7:0]  first_source_field_i,      // First source reg
    input  wire [7:0]  second_source_field_i,     // Second source reg
    input  wire [3:0]  operand_function_code_i,   // Function code
    input  wire [1:0]  accumulator_selector_i,    // Accumulator number
    output reg         busy_o,                    // Unit busy
    output reg         done_o,                    // Result written
    output reg         trap_o                     // Exception trap
);

localparam [1:0] st_idle = 2'd0;
localparam [1:0] st_exec = 2'd1;
localparam [1:0] st_div  = 2'd2;

reg  [8:0]  env;
reg  [4:0]  sticky;
reg  [4:0]  mask;
reg  [31:0] gpr [0:255];
reg  [63:0] acc [0:3];
reg  [1:0]  state;
reg  [7:0]  op;
reg  [7:0]  rc;
reg  [3:0]  fn;
reg  [1:0]  an;
reg  [31:0] opa;
reg  [31:0] opb;
reg  [25:0] dq;
reg  [25:0] drem;
reg  [23:0] dmb;
reg  [4:0]  dcnt;
reg         ds;
reg  [11:0] de;
integer     k;

function nanf;
    input [31:0] a;
    nanf = (&a[30:23]) & (|a[22:0]);
endfunction

function inff;
    input [31:0] a;
    inff = (&a[30:23]) & ~(|a[22:0]);
endfunction

// Mantissa is pre-normalised so denormal operands need no special path
function [33:0] unp;
    input [31:0] a;
    input        ff;
    reg   [23:0] m;
    reg   [9:0]  e;
    integer      i;
    begin
        m = {|a[30:23], a[22:0]};
        e = (a[30:23] == 8'h00) ? 10'h001 : {2'b00, a[30:23]};
        if (ff && a[30:23] == 8'h00)
            m = 24'h000000;
        for (i = 0; i < 23; i = i + 1)
            if (!m[23] && m != 24'h000000) begin
                m = {m[22:0], 1'b0};
                e = e - 10'h001;
            end
        unp = {e, m};
    end
endfunction

// Value is m * 2^(e - 175); returns {inexact, underflow, overflow, result}
function [34:0] rnd;
    input        s;
    input [11:0] e;
    input [53:0] m;
    input [1:0]  rm;
    input        ff;
    reg   [53:0] w;
    reg   [11:0] x;
    reg   [24:0] f;
    reg   [11:0] ef;
    reg          g;
    reg          st;
    reg          inc;
    reg          ux;
    integer      i;
    begin
        w = m;
        x = e;
        for (i = 0; i < 5; i = i + 1)
            if (|w[53:49]) begin
                w = {1'b0, w[53:1]} | {53'h0, w[0]};
                x = x + 12'h001;
            end
        for (i = 0; i < 48; i = i + 1)
            if (!w[48] && w != 54'h0) begin
                w = {w[52:0], 1'b0};
                x = x - 12'h001;
            end
        for (i = 0; i < 30; i = i + 1)
            if ($signed(x) < 12'sd1) begin
                w = {1'b0, w[53:1]} | {53'h0, w[0]};
                x = x + 12'h001;
            end
        g  = w[24];
        st = |w[23:0];
        case (rm)
            `RM_NEAR: inc = g & (st | w[25]);
            `RM_DOWN: inc = s & (g | st);
            `RM_UP:   inc = ~s & (g | st);
            default:  inc = 1'b0;
        endcase
        f  = {1'b0, w[48:25]} + {24'h0, inc};
        ef = f[24] ? x + 12'h001 : (f[23] ? x : 12'h000);
        ux = (ef == 12'h000) && (f[22:0] != 23'h0);
        rnd = {g | st, ux & (g | st), 1'b0, s, ef[7:0], f[22:0]};
        if (w == 54'h0)
            rnd = {3'b000, s, 31'h0};
        else if ($signed(ef) >= 12'sd255) begin
            if (rm == `RM_ZERO || (rm == `RM_DOWN && !s) ||
                (rm == `RM_UP && s))
                rnd = {3'b101, s, `MAX_S};
            else
                rnd = {3'b101, s, `INF_S};
        end else if (ff && ef == 12'h000)
            rnd = {1'b0, 2'b10, s, 31'h0};
    end
endfunction

// Aligned add of two internal values; the shifted-out part stays sticky
function [66:0] fadd;
    input        sa;
    input [11:0] ea;
    input [53:0] ma;
    input        sb;
    input [11:0] eb;
    input [53:0] mb;
    reg          sw;
    reg          s;
    reg   [11:0] e;
    reg   [11:0] d;
    reg   [53:0] t;
    reg   [53:0] u;
    integer      i;
    begin
        sw = $signed(ea) < $signed(eb);
        t  = sw ? mb : ma;
        u  = sw ? ma : mb;
        s  = sw ? sb : sa;
        e  = sw ? eb : ea;
        d  = sw ? eb - ea : ea - eb;
        for (i = 0; i < 56; i = i + 1)
            if (i < d)
                u = {1'b0, u[53:1]} | {53'h0, u[0]};
        if (sa == sb)
            t = t + u;
        else if (t >= u)
            t = t - u;
        else begin
            t = u - t;
            s = ~s;
        end
        if (t == 54'h0)
            s = 1'b0;
        fadd = {s, e, t};
    end
endfunction

function [63:0] s2d;
    input [31:0] a;
    begin
        if (a[30:23] == 8'h00)
            s2d = {a[31], 63'h0};
        else if (&a[30:23])
            s2d = {a[31], 11'h7ff, a[22:0], 29'h0};
        else
            s2d = {a[31], {3'b000, a[30:23]} + `S2D_BIAS, a[22:0], 29'h0};
    end
endfunction

function [31:0] d2s;
    input [63:0] a;
    reg   [10:0] e;
    begin
        e = a[62:52] - `S2D_BIAS;
        if (a[62:52] <= `S2D_BIAS)
            d2s = {a[63], 31'h0};
        else if (a[62:52] >= 11'd1151)
            d2s = {a[63], 8'hff, (&a[62:52]) ? a[51:29] : 23'h0};
        else
            d2s = {a[63], e[7:0], a[51:29]};
    end
endfunction

function signed [32:0] key;
    input [31:0] a;
    input        ff;
    reg   [32:0] mg;
    begin
        mg = {2'b00, a[30:0]};
        if (ff && a[30:23] == 8'h00)
            mg = 33'h0;
        key = a[31] ? -$signed(mg) : $signed(mg);
    end
endfunction

reg         isf;
reg         ffm;
reg  [31:0] acs;
reg  [31:0] y;
reg  [31:0] z;
reg  [33:0] ux;
reg  [33:0] uy;
reg  [33:0] uz;
reg  [47:0] p;
reg  [11:0] pe;
reg         ps;
reg  [66:0] sum;
reg  [34:0] r;
reg  [47:0] pn;
reg  [11:0] dx;
reg         sp_nan;
reg         sp_inv;
reg         c_fin;
reg         c_div;
reg         c_wr2;
reg         c_accw;
reg  [31:0] c_hi;
reg  [31:0] c_lo;
reg  [4:0]  c_fl;
reg  [4:0]  next_sticky;

always @* begin
    isf = (op == multiply_accumulate_op) || (op == multiply_sum_op);
    ffm = isf | env[`ENV_FF_BIT];
    acs = env[`ENV_ACF_BIT] ? d2s(acc[(op == multiply_sum_op) ? 2'd0 : an])
        : acc[(op == multiply_sum_op) ? 2'd0 : an][31:0];
    y = opb;
    z = 32'h0;
    if (op == float_subtract_op) begin
        y = `ONE_S;
        z = {~opb[31], opb[30:0]};
    end else if (op == multiply_sum_op) begin
        y = acs;
        z = opb;
    end else if (op == multiply_accumulate_op) begin
        y = fn[3] ? `ONE_S : opb;
        y = {y[31] ^ fn[0], y[30:0]};
        z = fn[2] ? 32'h0 : acs;
        z = {z[31] ^ fn[1], z[30:0]};
    end
    ux = unp(opa, ffm);
    uy = unp(y, ffm);
    uz = unp(z, ffm);
    p  = ux[23:0] * uy[23:0];
    pe = {{2{ux[33]}}, ux[33:24]} + {{2{uy[33]}}, uy[33:24]} - `EXP_BIAS;
    ps = opa[31] ^ y[31];
    if (state == st_div)
        sum = {ds, de, 5'h0, dq, |drem, 22'h0};
    else if (uz[23:0] == 24'h0)
        sum = {ps, pe, 4'h0, p, 2'b00};
    else if (p == 48'h0)
        sum = {z[31], {{2{uz[33]}}, uz[33:24]}, 5'h0, uz[23:0], 25'h0};
    else
        sum = fadd(ps, pe, {4'h0, p, 2'b00}, z[31],
                   {{2{uz[33]}}, uz[33:24]}, {5'h0, uz[23:0], 25'h0});
    r  = rnd(sum[66], sum[65:54], sum[53:0], env[`ENV_RM_HI:`ENV_RM_LO],
             ffm);
    pn = p[47] ? p : {p[46:0], 1'b0};
    dx = pe + `EXP_BIAS + `DBL_MUL_BIAS - {11'h0, ~p[47]};
    sp_nan = nanf(opa) | nanf(y) | nanf(z);
    sp_inv = ((inff(opa) | inff(y)) &
              (ux[23:0] == 24'h0 | uy[23:0] == 24'h0)) |
             ((inff(opa) | inff(y)) & inff(z) & (ps != z[31]));
    c_fin  = 1'b0;
    c_div  = 1'b0;
    c_wr2  = 1'b0;
    c_accw = 1'b0;
    c_hi   = r[31:0];
    c_lo   = 32'h0;
    c_fl   = {2'b00, r[32], r[33], r[34]};
    if (state == st_div)
        c_fin = (dcnt == `DIV_STEPS);
    else if (state == st_exec) begin
        c_fin = 1'b1;
        case (op)
            float_equal_op, `OP_FGE, float_gt_op: begin
                c_fl = {nanf(opa) | nanf(opb), 4'h0};
                if (nanf(opa) | nanf(opb))
                    c_hi = `BOOL_FALSE;
                else if (op == float_equal_op)
                    c_hi = (key(opa, env[`ENV_FF_BIT]) ==
                            key(opb, env[`ENV_FF_BIT])) ?
                           `BOOL_TRUE : `BOOL_FALSE;
                else if (op == `OP_FGE)
                    c_hi = (key(opa, env[`ENV_FF_BIT]) >=
                            key(opb, env[`ENV_FF_BIT])) ?
                           `BOOL_TRUE : `BOOL_FALSE;
                else
                    c_hi = (key(opa, env[`ENV_FF_BIT]) >
                            key(opb, env[`ENV_FF_BIT])) ?
                           `BOOL_TRUE : `BOOL_FALSE;
            end
            widening_multiply_op: begin
                c_wr2 = 1'b1;
                c_fl  = 5'h0;
                {c_hi, c_lo} = {ps, dx[10:0], pn[46:0], 5'h0};
                if (sp_nan) begin
                    c_fl = 5'h08;
                    {c_hi, c_lo} = `QNAN_D;
                end else if (sp_inv) begin
                    c_fl = 5'h10;
                    {c_hi, c_lo} = `QNAN_D;
                end else if (inff(opa) | inff(opb))
                    {c_hi, c_lo} = {ps, 11'h7ff, 52'h0};
                else if (p == 48'h0)
                    {c_hi, c_lo} = {ps, 63'h0};
            end
            float_divide_op: begin
                c_fin = 1'b0;
                if (sp_nan) begin
                    c_fin = 1'b1;
                    c_fl  = 5'h08;
                    c_hi  = `QNAN_S;
                end else if ((inff(opa) & inff(opb)) |
                             (ux[23:0] == 24'h0 & uy[23:0] == 24'h0)) begin
                    c_fin = 1'b1;
                    c_fl  = 5'h10;
                    c_hi  = `QNAN_S;
                end else if (inff(opa) | uy[23:0] == 24'h0) begin
                    c_fin = 1'b1;
                    c_fl  = 5'h0;
                    c_hi  = {ps, `INF_S};
                end else if (inff(opb) | ux[23:0] == 24'h0) begin
                    c_fin = 1'b1;
                    c_fl  = 5'h0;
                    c_hi  = {ps, 31'h0};
                end else
                    c_div = 1'b1;
            end
            default: begin
                if (sp_nan) begin
                    c_fl = 5'h08;
                    c_hi = `QNAN_S;
                end else if (sp_inv) begin
                    c_fl = 5'h10;
                    c_hi = `QNAN_S;
                end else if (inff(opa) | inff(y)) begin
                    c_fl = 5'h0;
                    c_hi = {ps, `INF_S};
                end else if (inff(z)) begin
                    c_fl = 5'h0;
                    c_hi = z;
                end
                if (isf)
                    c_fl[`FLAG_X] = 1'b0;
                c_accw = (op == multiply_accumulate_op);
            end
        endcase
    end
    next_sticky = sticky;
    if (wr_i && addr_i == `ADDR_STICKY)
        next_sticky = sticky & ~wdata_i[4:0];
    if (c_fin)
        next_sticky = next_sticky | c_fl;
end

always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        env     <= `ENV_RESET;
        sticky  <= 5'h0;
        mask    <= 5'h0;
        state   <= st_idle;
        op      <= 8'h0;
        rc      <= 8'h0;
        fn      <= 4'h0;
        an      <= 2'h0;
        opa     <= 32'h0;
        opb     <= 32'h0;
        dq      <= 26'h0;
        drem    <= 26'h0;
        dmb     <= 24'h0;
        dcnt    <= 5'h0;
        ds      <= 1'b0;
        de      <= 12'h0;
        rdata_o <= 32'h0;
        irq_o   <= 1'b0;
        busy_o  <= 1'b0;
        done_o  <= 1'b0;
        trap_o  <= 1'b0;
        for (k = 0; k < 4; k = k + 1)
            acc[k] <= 64'h0;
    end else begin
        sticky <= next_sticky;
        irq_o  <= |(next_sticky & mask);
        done_o <= c_fin;
        // Fused ops never trap; the others trap on an enabled flag
        trap_o <= c_fin & ~isf &
                  (|(c_fl & env[`ENV_TRAP_HI:`ENV_TRAP_LO]));
        if (wr_i && addr_i == `ADDR_ENV)
            env <= wdata_i[8:0];
        if (wr_i && addr_i == `ADDR_MASK)
            mask <= wdata_i[4:0];
        rdata_o <= 32'h0;
        if (rd_i) begin
            if (addr_i[`ADDR_GPR_BIT])
                rdata_o <= gpr[addr_i[9:2]];
            else if (addr_i == `ADDR_ENV)
                rdata_o <= {23'h0, env};
            else if (addr_i == `ADDR_STICKY)
                rdata_o <= {27'h0, sticky};
            else if (addr_i == `ADDR_MASK)
                rdata_o <= {27'h0, mask};
        end
        if (c_accw)
            acc[an] <= env[`ENV_ACF_BIT] ? s2d(c_hi)
                     : {32'h0, c_hi};
        case (state)
            st_idle: begin
                if (issue_i) begin
                    opa    <= gpr[first_source_field_i];
                    opb    <= gpr[second_source_field_i];
                    op     <= opcode_i;
                    rc     <= destination_field_i;
                    fn     <= operand_function_code_i;
                    an     <= accumulator_selector_i;
                    state  <= st_exec;
                    busy_o <= 1'b1;
                end
            end
            st_exec: begin
                if (c_div) begin
                    drem  <= {2'b00, ux[23:0]};
                    dmb   <= uy[23:0];
                    dq    <= 26'h0;
                    dcnt  <= 5'h0;
                    ds    <= ps;
                    de    <= {{2{ux[33]}}, ux[33:24]} -
                             {{2{uy[33]}}, uy[33:24]} + `EXP_BIAS;
                    state <= st_div;
                end else begin
                    state  <= st_idle;
                    busy_o <= 1'b0;
                end
            end
            st_div: begin
                if (c_fin) begin
                    state  <= st_idle;
                    busy_o <= 1'b0;
                end else begin
                    // One quotient bit a cycle keeps the divider small
                    dq   <= {dq[24:0], drem >= {2'b00, dmb}};
                    drem <= (drem >= {2'b00, dmb}) ?
                            {drem[24:0] - {1'b0, dmb}, 1'b0} :
                            {drem[24:0], 1'b0};
                    dcnt <= dcnt + 5'h01;
                end
            end
            default: begin
                state  <= st_idle;
                busy_o <= 1'b0;
            end
        endcase
    end
end

// Register file has no reset; a result write wins over a bus write
always @(posedge clk_i) begin
    if (wr_i && addr_i[`ADDR_GPR_BIT])
        gpr[addr_i[9:2]] <= wdata_i;
    if (c_fin && !c_accw)
        gpr[rc] <= c_hi;
    if (c_fin && c_wr2)
        gpr[rc + 8'h01] <= c_lo;
end

endmodule

// [logic/fp_execute_consts.vh]
`ifndef FP_EXECUTE_CONSTS_VH
`define FP_EXECUTE_CONSTS_VH

`define ADDR_ENV     12'h000
`define ADDR_STICKY  12'h004
`define ADDR_MASK    12'h008
`define ADDR_GPR_BIT 10

`define ENV_RM_HI    1
`define ENV_RM_LO    0
`define ENV_FF_BIT   2
`define ENV_ACF_BIT  3
`define ENV_TRAP_HI  8
`define ENV_TRAP_LO  4
`define ENV_RESET    9'h000

`define FLAG_X       0
`define FLAG_U       1
`define FLAG_V       2
`define FLAG_R       3
`define FLAG_N       4

`define RM_NEAR      2'h0
`define RM_DOWN      2'h1
`define RM_UP        2'h2
`define RM_ZERO      2'h3

`define OP_FLOAT_MULTIPLY_OP      8'hf4
`define OP_FGE       8'hee

`define ONE_S        32'h3f800000
`define QNAN_S       32'h7fc00000
`define QNAN_D       64'h7ff8000000000000
`define MAX_S        31'h7f7fffff
`define INF_S        31'h7f800000
`define BOOL_TRUE    32'h80000000
`define BOOL_FALSE   32'h00000000
`define EXP_BIAS     12'sd127
`define S2D_BIAS     11'd896
`define DBL_MUL_BIAS 12'sd770
`define DIV_STEPS    5'd26

`endif

// [tb/fp_execute_props.sv]
`timescale 1ns/1ns
`include "fp_execute_consts.vh"
module fp_execute_props #(
    parameter [7:0] float_divide_op        = 8'he0, // Divide code
    parameter [7:0] multiply_accumulate_op = 8'he4, // Accumulate code
    parameter [7:0] multiply_sum_op        = 8'he5  // Sum code
) (
    input wire        clk_i,    // Core clock
    input wire        rst_i,    // Async reset
    input wire [11:0] addr_i,   // Address
    input wire [31:0] wdata_i,  // Write data
    input wire        wr_i,     // Write strobe
    input wire        rd_i,     // Read strobe
    input wire [31:0] rdata_o,  // Read data
    input wire        irq_o,    // Interrupt
    input wire        issue_i,  // Issue
    input wire [7:0]  opcode_i, // Opcode
    input wire        busy_o,   // Busy
    input wire        done_o,   // Done
    input wire        trap_o    // Trap
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire take  = issue_i && !busy_o;
    wire fused = opcode_i == multiply_accumulate_op ||
                 opcode_i == multiply_sum_op;
    a_fused_no_trap:
        assert property (take && fused |-> ##2 (done_o && !trap_o))
        else $error("fused op trapped or late");
    a_result_slot:
        assert property (take && opcode_i != float_divide_op |=>
                         (busy_o && !done_o) ##1 (done_o && !busy_o))
        else $error("result not in its slot");
    a_divide_ends:
        assert property (take && opcode_i == float_divide_op |->
                         ##[2:30] done_o)
        else $error("divide not completed");
    a_done_single:
        assert property (done_o |=> !done_o)
        else $error("done too long");
    a_trap_beside:
        assert property (trap_o |-> done_o)
        else $error("trap without done");
    a_irq_masked:
        assert property (wr_i && addr_i == `ADDR_MASK &&
                         wdata_i == 32'h0 |-> ##2 !irq_o)
        else $error("irq with zero mask");
    a_rdata_idle:
        assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside slot");
    a_sticky_width:
        assert property (rd_i && addr_i == `ADDR_STICKY |=>
                         rdata_o[31:5] == 27'h0)
        else $error("sticky beyond five flags");
    c_fused: cover property (take && fused);
    c_trap: cover property (trap_o);
    c_irq: cover property (irq_o);
endmodule
bind fp_execute fp_execute_props #(
    .float_divide_op(float_divide_op),
    .multiply_accumulate_op(multiply_accumulate_op),
    .multiply_sum_op(multiply_sum_op)
) u_props (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .issue_i(issue_i), .opcode_i(opcode_i),
    .busy_o(busy_o), .done_o(done_o), .trap_o(trap_o));

// [tb/pipe_model.sv]
`timescale 1ns/1ns
module pipe_model (
    input  wire       clk_i,   // Core clock
    input  wire       done_i,  // Result written
    input  wire       trap_i,  // Trap pulse
    output reg        issue_o, // Issue strobe
    output reg  [7:0] op_o,    // Opcode
    output reg  [7:0] dst_o,   // Destination number
    output reg  [7:0] src1_o,  // First source number
    output reg  [7:0] src2_o,  // Second source number
    output reg  [3:0] fcode_o, // Function code
    output reg  [1:0] sel_o    // Accumulator number
);
    initial begin
        issue_o = 1'b0;
        {op_o, dst_o, src1_o, src2_o, fcode_o, sel_o} = 38'h0;
    end
    // One instruction at a time, so busy is always low when we issue
    task run(input [7:0] op, input [7:0] d, input [3:0] fc,
             input [1:0] s, output reg tr);
        integer n;
        begin
            issue_o <= 1'b1;
            {op_o, dst_o, src1_o, src2_o, fcode_o, sel_o} <=
                {op, d, 8'd1, 8'd2, fc, s};
            @(posedge clk_i);
            issue_o <= 1'b0;
            n = 0;
            while (done_i !== 1'b1 && n < 64) begin
                @(negedge clk_i);
                n = n + 1;
            end
            // A lost completion turns the trap into x so it cannot match
            tr = (n < 64) ? trap_i : 1'bx;
            @(posedge clk_i);
        end
    endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ns
`include "fp_execute_consts.vh"
`define CHK(n, e, g) begin samples_checked = samples_checked + 1; \
    if ((g) !== (e)) begin num_errors = num_errors + 1; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
    reg          clk_i   = 1'b0;
    reg          rst_i   = 1'b1;
    reg  [11:0]  addr_i  = 12'h000;
    reg  [31:0]  wdata_i = 32'h0;
    reg          wr_i    = 1'b0;
    reg          rd_i    = 1'b0;
    wire [31:0]  rdata_o;
    wire         irq_o, busy_o, done_o, trap_o, issue;
    wire [7:0]   op, dst, src1, src2;
    wire [3:0]   fcode;
    wire [1:0]   sel;
    integer      num_errors      = 0;
    integer      samples_checked = 0;
    integer      i;
    reg  [31:0]  got;
    reg          tr;
    reg  [103:0] rows [0:6];
    reg  [35:0]  macs [0:3];
    fp_execute dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .irq_o(irq_o), .issue_i(issue), .opcode_i(op),
        .destination_field_i(dst), .first_source_field_i(src1),
        .second_source_field_i(src2), .operand_function_code_i(fcode),
        .accumulator_selector_i(sel), .busy_o(busy_o),
        .done_o(done_o), .trap_o(trap_o));
    pipe_model pipe (.clk_i(clk_i), .done_i(done_o), .trap_i(trap_o),
        .issue_o(issue), .op_o(op), .dst_o(dst), .src1_o(src1),
        .src2_o(src2), .fcode_o(fcode), .sel_o(sel));
    initial forever #4 clk_i = ~clk_i;
    function [11:0] gpr(input [7:0] n);
        gpr = {2'b01, n, 2'b00};
    endfunction
    task wr(input [11:0] a, input [31:0] d);
        begin
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            @(posedge clk_i);
            wr_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    task rd(input [11:0] a, input [31:0] e, input [8*8-1:0] n);
        begin
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge clk_i);
            rd_i <= 1'b0;
            @(negedge clk_i);
            got = rdata_o;
            `CHK(n, e, got)
            @(posedge clk_i);
        end
    endtask
    task ld(input [31:0] a, input [31:0] b);
        begin
            wr(gpr(8'd1), a);
            wr(gpr(8'd2), b);
        end
    endtask
    task exec(input [7:0] o, input [7:0] d, input [3:0] fc,
              input [1:0] s, input etr);
        begin
            pipe.run(o, d, fc, s, tr);
            `CHK("trap", etr, tr)
        end
    endtask
    task irq_chk(input e);
        begin
            @(negedge clk_i);
            `CHK("irq", e, irq_o)
            @(posedge clk_i);
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d errors %0d", samples_checked, num_errors);
            if (num_errors == 0 && samples_checked > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors = num_errors + 1;
        print_verdict;
    end
    initial begin
        rows[0] = {8'hf4, 32'h40000000, 32'h40400000, 32'h40c00000};
        rows[1] = {8'he6, 32'h40400000, 32'h40000000, 32'h3f800000};
        rows[2] = {8'he0, 32'h40c00000, 32'h40400000, 32'h40000000};
        rows[3] = {8'he2, 32'h40000000, 32'h40000000, `BOOL_TRUE};
        rows[4] = {8'hee, 32'h40000000, 32'h40000000, `BOOL_TRUE};
        rows[5] = {8'hee, 32'h40000000, 32'h40400000, `BOOL_FALSE};
        rows[6] = {8'he3, 32'h40000000, 32'h40000000, `BOOL_FALSE};
        macs[0] = {4'h0, 32'h40c00000};
        macs[1] = {4'h3, 32'hc1400000};
        macs[2] = {4'h2, 32'h41900000};
        macs[3] = {4'h1, 32'h41400000};
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (i = 0; i < 16; i = i + 4)
            rd(i[11:0], 32'h0, "reset");
        $display("reset test done");
        for (i = 0; i < 7; i = i + 1) begin
            ld(rows[i][95:64], rows[i][63:32]);
            exec(rows[i][103:96], 8'd8 + i[7:0], 4'h0, 2'h0, 1'b0);
            rd(gpr(8'd8 + i[7:0]), rows[i][31:0], "row");
        end
        $display("row test done");
        wr(`ADDR_ENV, {30'h0, `RM_UP});
        ld(32'h3f800001, 32'h3f800001);
        exec(`OP_FLOAT_MULTIPLY_OP, 8'd3, 4'h0, 2'h0, 1'b0);
        rd(gpr(8'd3), 32'h3f800003, "float_multiply_op up");
        rd(`ADDR_STICKY, 32'h1, "inexact");
        wr(`ADDR_MASK, 32'h1);
        irq_chk(1'b1);
        wr(`ADDR_MASK, 32'h0);
        irq_chk(1'b0);
        wr(`ADDR_MASK, 32'h1);
        irq_chk(1'b1);
        wr(`ADDR_STICKY, 32'h1);
        irq_chk(1'b0);
        // Exact product must ignore rounding up and leave inexact clear
        exec(8'he1, 8'd4, 4'h0, 2'h0, 1'b0);
        rd(gpr(8'd4), 32'h3ff00000, "dbl hi");
        rd(gpr(8'd5), 32'h40000040, "dbl lo");
        rd(`ADDR_STICKY, 32'h0, "dbl flag");
        ld(32'h3f800001, 32'h3f800000);
        exec(8'he3, 8'd3, 4'h0, 2'h0, 1'b0);
        rd(gpr(8'd3), `BOOL_TRUE, "gt up");
        ld(`QNAN_S, 32'h3f800000);
        exec(8'he2, 8'd3, 4'h0, 2'h0, 1'b0);
        rd(gpr(8'd3), `BOOL_FALSE, "eq nan");
        rd(`ADDR_STICKY, 32'h10, "cmp flag");
        $display("flag test done");
        // Trap on inexact, single accumulator format for the sum ops
        wr(`ADDR_ENV, 32'h10);
        ld(32'h3f800001, 32'h3f800001);
        exec(`OP_FLOAT_MULTIPLY_OP, 8'd3, 4'h0, 2'h0, 1'b1);
        wr(`ADDR_STICKY, 32'h1f);
        exec(8'he4, 8'd0, 4'h0, 2'h1, 1'b0);
        rd(`ADDR_STICKY, 32'h0, "mac flag");
        for (i = 0; i < 4; i = i + 1) begin
            ld(32'h40000000, 32'h40400000);
            exec(8'he4, 8'd0, macs[i][35:32], 2'h0, 1'b0);
            ld(`ONE_S, 32'h0);
            exec(8'he5, 8'd3, 4'h0, 2'h0, 1'b0);
            rd(gpr(8'd3), macs[i][31:0], "mac fn");
        end
        for (i = 1; i < 4; i = i + 1) begin
            ld(32'h40000000, 32'h40400000);
            exec(8'he4, 8'd0, 4'h0, i[1:0], 1'b0);
        end
        // Denormal addend is flushed even with fast-float select off
        ld(`ONE_S, 32'h1);
        wr(`ADDR_STICKY, 32'h1f);
        exec(8'he5, 8'd6, 4'h0, 2'h0, 1'b0);
        rd(gpr(8'd6), 32'h41400000, "sum sel");
        rd(`ADDR_STICKY, 32'h0, "mac inex");
        ld(32'h1, 32'h1);
        exec(8'he5, 8'd6, 4'h0, 2'h0, 1'b0);
        rd(gpr(8'd6), 32'h0, "flush");
        // Double format keeps the low mantissa bits in the low word
        wr(`ADDR_ENV, 32'h8);
        ld(32'h3f800001, `ONE_S);
        exec(8'he4, 8'd0, 4'h4, 2'h0, 1'b0);
        wr(`ADDR_ENV, 32'h0);
        ld(`ONE_S, 32'h0);
        exec(8'he5, 8'd6, 4'h0, 2'h0, 1'b0);
        rd(gpr(8'd6), 32'h20000000, "acc dbl");
        $display("fused test done");
        print_verdict;
    end
endmodule
